// ---- hdl/epio_port.sv ----
// eight pin parallel i/o port with ahb-lite register slave
// Operation
// RULE1: eight pins, each input or output
// RULE2: direction one floats pin, zero drives latch
// RULE3: latch register reads back latch, not pins
// RULE4: neighbour bit seven enables all pull-ups
// RULE5: pull-up off when output or peripheral
// RULE6: reset leaves every pull-up disabled
// RULE7: reset makes every pin an input
// RULE8: stream mode selects ttl input buffers
// RULE9: stream output overrides latch, input sees pins
// RULE10: pwm b, c, d override pins 5-7
// RULE11: dual or quad pwm disables stream
// RULE12: enabled pull-ups follow each latch bit
// RULE13: port data reads pins, writes latch
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "epio_cfg.svh"
module epio_port import epio_pkg::*; #(
  parameter int PWM_BASE = `EPIO_PWM_BASE
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // package pins
  input wire logic [`EPIO_W-1:0] pin_in,
  output logic [`EPIO_W-1:0] pin_out,
  output logic [`EPIO_W-1:0] pin_oe_n,
  output logic [`EPIO_W-1:0] pullup_en,
  output logic ttl_sel,
  // streaming parallel port engine
  input wire logic stream_drive,
  input wire logic [`EPIO_W-1:0] stream_out_data,
  output logic [`EPIO_W-1:0] stream_in_data,
  output logic stream_active,
  // enhanced pwm channels b, c, d in bits 0, 1, 2
  input wire logic pwm_multi_mode,
  input wire logic [`EPIO_PWM_N-1:0] pwm_chan_act,
  input wire logic [`EPIO_PWM_N-1:0] pwm_chan_out
);

  //////////////////////////////////////////////////////////////////////
  // declarations

  epio_regs_t st_r; // all register and bus state
  epio_regs_t st_nxt; // its next value
  logic take; // address phase accepted this edge
  logic strm_act; // stream function really owns the port
  logic [`EPIO_AW-1:0] a_ofs; // offset of the new address phase
  logic [`EPIO_W-1:0] wbyte; // write data, low byte only
  logic [31:0] rd_nxt; // read data for the next data phase

  // only the low byte lane carries data, upper bits are ignored
  assign wbyte = hwdata[`EPIO_W-1:0];
  assign a_ofs = haddr[`EPIO_AW-1:0];

  // accepted transfers: selected, nonseq or seq, bus ready
  assign take = hsel & htrans[`EPIO_HTRANS_ACT_BIT] & hready;

  //////////////////////////////////////////////////////////////////////
  // stream ownership

  // RULE11: multi output pwm blocks stream
  assign strm_act = st_r.strm_en & ~pwm_multi_mode;

  //////////////////////////////////////////////////////////////////////
  // register file and bus phase tracking
  always_comb begin
    st_nxt = st_r;
    rd_nxt = `EPIO_RST_RDATA;

    // data phase of a write: hwdata is valid now
    if (st_r.ph == EPIO_PH_WR) begin
      case (st_r.addr)
        // RULE13: port write loads latch
        `EPIO_OFS_PORT: begin
          st_nxt.latch = wbyte;
        end
        // RULE3: latch write stores latch
        `EPIO_OFS_LATCH: begin
          st_nxt.latch = wbyte;
        end
        // RULE2: direction bits written
        `EPIO_OFS_DIR: begin
          st_nxt.dir = wbyte;
        end
        // RULE4: global pull-up enable bit
        `EPIO_OFS_NBR: begin
          st_nxt.pu_glob = wbyte[`EPIO_PU_BIT];
        end
        // stream function enable
        `EPIO_OFS_STRM: begin
          st_nxt.strm_en = wbyte[`EPIO_STRM_EN_BIT];
        end
        // unmapped: write is dropped, answer stays okay
        default: begin
          st_nxt.latch = st_r.latch;
        end
      endcase
    end

    // read mux works on the updated values, so a read that
    // follows a write back to back already sees the new data
    case (a_ofs)
      // RULE13: port read returns pins
      `EPIO_OFS_PORT: begin
        rd_nxt[`EPIO_W-1:0] = pin_in;
      end
      // RULE3: latch read returns latch
      `EPIO_OFS_LATCH: begin
        rd_nxt[`EPIO_W-1:0] = st_nxt.latch;
      end
      `EPIO_OFS_DIR: begin
        rd_nxt[`EPIO_W-1:0] = st_nxt.dir;
      end
      // other bits of the neighbour word read as zero here
      `EPIO_OFS_NBR: begin
        rd_nxt[`EPIO_PU_BIT] = st_nxt.pu_glob;
      end
      `EPIO_OFS_STRM: begin
        rd_nxt[`EPIO_STRM_EN_BIT] = st_nxt.strm_en;
      end
      // unmapped reads return zero
      default: begin
        rd_nxt = `EPIO_RST_RDATA;
      end
    endcase

    // next bus phase
    if (take) begin
      st_nxt.addr = a_ofs;
      if (hwrite) begin
        st_nxt.ph = EPIO_PH_WR;
      end else begin
        st_nxt.ph = EPIO_PH_RD;
        st_nxt.rdata = rd_nxt;
      end
    end else begin
      st_nxt.ph = EPIO_PH_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register
  // synchronous reset: power-on values of the port
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r.latch <= `EPIO_RST_LATCH;
      // RULE7: all pins inputs
      st_r.dir <= `EPIO_RST_DIR;
      // RULE6: pull-ups start disabled
      st_r.pu_glob <= `EPIO_RST_PU;
      st_r.strm_en <= `EPIO_RST_STRM;
      st_r.ph <= EPIO_PH_IDLE;
      st_r.addr <= `EPIO_OFS_PORT;
      st_r.rdata <= `EPIO_RST_RDATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bus outputs
  // the slave never stalls; every access finishes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign stream_active = strm_act;

  //////////////////////////////////////////////////////////////////////
  // pin multiplexer
  // RULE1: eight individual pins
  // RULE12: pull-ups follow latch bits
  // pins are registered once more, so a write reaches the pads
  // one edge after its data phase; trades a cycle for clean pads
  epio_pinmux #(
    .PWM_BASE(PWM_BASE)
  ) u_mux (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .latch(st_r.latch),
    .dir(st_r.dir),
    .pu_glob(st_r.pu_glob),
    .strm_act(strm_act),
    .strm_drive(stream_drive),
    .strm_dout(stream_out_data),
    .pwm_act(pwm_chan_act),
    .pwm_dat(pwm_chan_out),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en),
    .strm_din(stream_in_data),
    .ttl_sel(ttl_sel)
  );

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // write data phase on a given offset
  logic wr_latch; // latch register written now
  logic wr_port; // port data register written now
  assign wr_latch = (st_r.ph == EPIO_PH_WR) &&
                    (st_r.addr == `EPIO_OFS_LATCH);
  assign wr_port = (st_r.ph == EPIO_PH_WR) &&
                   (st_r.addr == `EPIO_OFS_PORT);

  // RULE3: latch write stored in latch
  a_latch_write: assert property ( // RULE3
    wr_latch |=> st_r.latch == $past(hwdata[`EPIO_W-1:0]))
    else $error("latch write not stored");

  // RULE13: port write lands in latch
  a_port_write: assert property ( // RULE13
    wr_port |=> st_r.latch == $past(hwdata[`EPIO_W-1:0]))
    else $error("port data write missed latch");

  // RULE3: latch read shows latch
  a_latch_read: assert property ( // RULE3
    take && !hwrite && a_ofs == `EPIO_OFS_LATCH && !wr_latch
      && !wr_port
    |=> hrdata == {24'h00_0000, $past(st_r.latch)})
    else $error("latch read wrong");

  // RULE13: port read shows pins
  a_port_read: assert property ( // RULE13
    take && !hwrite && a_ofs == `EPIO_OFS_PORT
    |=> hrdata[`EPIO_W-1:0] == $past(pin_in))
    else $error("port read did not return pins");

  // RULE2: latch driven on outputs
  a_dir_drive: assert property ( // RULE2
    !strm_act && pwm_chan_act == 3'h0 && $stable(st_r.dir)
      && $stable(st_r.latch)
    |=> pin_oe_n == $past(st_r.dir)
      && (pin_out & ~pin_oe_n) == ($past(st_r.latch) & ~$past(st_r.dir)))
    else $error("direction or latch not on pins");

  // RULE7: pins float after reset
  a_reset_input: assert property ( // RULE7
    $fell(sys_rst) |-> pin_oe_n == `EPIO_ONES_W && st_r.dir ==
      `EPIO_RST_DIR)
    else $error("pins not inputs after reset");

  // RULE6: pulls stay off after reset
  a_reset_pull: assert property ( // RULE6
    $fell(sys_rst) |-> pullup_en == `EPIO_ZERO_W ##1
      pullup_en == `EPIO_ZERO_W)
    else $error("pull-up on after reset");

  // RULE4: cleared enable kills pulls
  a_pull_global: assert property ( // RULE4
    !st_r.pu_glob ##1 !st_r.pu_glob |-> pullup_en == `EPIO_ZERO_W)
    else $error("pull-up on with enable clear");

  // RULE11: multi pwm drops stream
  a_multi_block: assert property ( // RULE11
    pwm_multi_mode |-> !stream_active ##1 !ttl_sel)
    else $error("stream active under multi pwm");

  // RULE8: stream gives ttl buffers
  a_stream_ttl: assert property ( // RULE8
    strm_act |=> ttl_sel)
    else $error("ttl buffers not chosen");

  // RULE9: stream data overrides latch
  a_stream_out: assert property ( // RULE9
    strm_act && stream_drive && pwm_chan_act == 3'h0
    |=> !pin_oe_n[0] && pin_out == $past(stream_out_data))
    else $error("stream data not on pins");

  // RULE2: direction write stored
  a_dir_write: assert property ( // RULE2
    st_r.ph == EPIO_PH_WR && st_r.addr == `EPIO_OFS_DIR
    |=> st_r.dir == $past(hwdata[`EPIO_W-1:0]))
    else $error("direction write not stored");

  // RULE4: enable bit written
  a_pull_write: assert property ( // RULE4
    st_r.ph == EPIO_PH_WR && st_r.addr == `EPIO_OFS_NBR
    |=> st_r.pu_glob == $past(hwdata[`EPIO_PU_BIT]))
    else $error("pull-up enable write not stored");

  // RULE12: pulls follow latch bits
  a_pull_follow: assert property ( // RULE12
    st_r.pu_glob && !strm_act && pwm_chan_act == 3'h0
    |=> pullup_en == ($past(st_r.latch) & $past(st_r.dir)))
    else $error("pull-ups do not follow latch");

  // RULE9: stream input sees pins
  a_stream_in: assert property ( // RULE9
    strm_act |=> stream_in_data == $past(pin_in))
    else $error("stream input not from pins");

  // RULE9: idle stream floats pins
  a_stream_float: assert property ( // RULE9
    strm_act && !stream_drive && pwm_chan_act == 3'h0
    |=> pin_oe_n == `EPIO_ONES_W)
    else $error("stream did not release pins");

  // RULE10: pwm b takes low pin
  a_low_pwm_pin: assert property ( // RULE10
    pwm_chan_act[0]
    |=> !pin_oe_n[PWM_BASE] && pin_out[PWM_BASE] == $past(pwm_chan_out[0]))
    else $error("pwm b did not take its pin");

  // RULE6: registers cleared by reset
  a_reset_regs: assert property ( // RULE6
    $fell(sys_rst) |-> st_r.latch == `EPIO_RST_LATCH
      && st_r.pu_glob == `EPIO_RST_PU && st_r.strm_en == `EPIO_RST_STRM)
    else $error("registers not at reset values");

  // RULE9: stream enable stored
  a_strm_write: assert property ( // RULE9
    st_r.ph == EPIO_PH_WR && st_r.addr == `EPIO_OFS_STRM
    |=> st_r.strm_en == $past(hwdata[`EPIO_STRM_EN_BIT]))
    else $error("stream enable write not stored");

  // RULE8: schmitt buffers otherwise
  a_ttl_off: assert property ( // RULE8
    !strm_act |=> !ttl_sel)
    else $error("ttl buffers without stream");

  // RULE3: read data holds
  a_rdata_hold: assert property ( // RULE3
    !(take && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  // RULE13: upper read bits zero
  a_read_upper: assert property ( // RULE13
    take && !hwrite |=> hrdata[31:`EPIO_W] == '0)
    else $error("upper read data bits set");

  // RULE11: multi pwm keeps direction register on pins
  a_multi_pins: assert property ( // RULE11
    pwm_multi_mode && pwm_chan_act == 3'h0
    |=> pin_oe_n == $past(st_r.dir))
    else $error("stream kept pins under multi pwm");
endmodule // epio_port

// ---- hdl/epio_cfg.svh ----
// constants of the eight pin parallel i/o port
`ifndef EPIO_CFG_SVH
`define EPIO_CFG_SVH
// port width and pin positions
`define EPIO_W 8
`define EPIO_PWM_BASE 5
`define EPIO_PWM_N 3
// decoded address bits of the register window
`define EPIO_AW 8
// register byte offsets, one aligned word each
`define EPIO_OFS_PORT 8'h00
`define EPIO_OFS_LATCH 8'h04
`define EPIO_OFS_DIR 8'h08
`define EPIO_OFS_NBR 8'h0C
`define EPIO_OFS_STRM 8'h10
// field positions
`define EPIO_PU_BIT 7
`define EPIO_STRM_EN_BIT 0
`define EPIO_HTRANS_ACT_BIT 1
// reset values
`define EPIO_RST_LATCH 8'h00
`define EPIO_RST_DIR 8'hFF
`define EPIO_RST_PU 1'b0
`define EPIO_RST_STRM 1'b0
`define EPIO_RST_RDATA 32'h0000_0000
`define EPIO_ZERO_W 8'h00
`define EPIO_ONES_W 8'hFF
`endif

// ---- hdl/epio_pkg.sv ----
// types of the eight pin parallel i/o port
`include "epio_cfg.svh"
package epio_pkg;
  // bus phase, gray along idle -> read -> write
  typedef enum logic [1:0] {
    EPIO_PH_IDLE = 2'b00,
    EPIO_PH_RD = 2'b01,
    EPIO_PH_WR = 2'b11
  } epio_phase_t;
  // register file and bus slave state
  typedef struct packed {
    logic [`EPIO_W-1:0] latch;
    logic [`EPIO_W-1:0] dir;
    logic pu_glob;
    logic strm_en;
    epio_phase_t ph;
    logic [`EPIO_AW-1:0] addr;
    logic [31:0] rdata;
  } epio_regs_t;
  // registered pin side outputs
  typedef struct packed {
    logic [`EPIO_W-1:0] pout;
    logic [`EPIO_W-1:0] oe_n;
    logic [`EPIO_W-1:0] pu;
    logic [`EPIO_W-1:0] din;
    logic ttl;
  } epio_pins_t;
endpackage

// ---- hdl/epio_pinmux.sv ----
// per pin output select, pull-up gating and input capture
`timescale 1ns/10ps
`include "epio_cfg.svh"
module epio_pinmux import epio_pkg::*; #(
  parameter int PWM_BASE = `EPIO_PWM_BASE
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [`EPIO_W-1:0] latch,
  input wire logic [`EPIO_W-1:0] dir,
  input wire logic pu_glob,
  input wire logic strm_act,
  input wire logic strm_drive,
  input wire logic [`EPIO_W-1:0] strm_dout,
  input wire logic [`EPIO_PWM_N-1:0] pwm_act,
  input wire logic [`EPIO_PWM_N-1:0] pwm_dat,
  input wire logic [`EPIO_W-1:0] pin_in,
  output logic [`EPIO_W-1:0] pin_out,
  output logic [`EPIO_W-1:0] pin_oe_n,
  output logic [`EPIO_W-1:0] pullup_en,
  output logic [`EPIO_W-1:0] strm_din,
  output logic ttl_sel
);
  epio_pins_t st_r; // registered pin state
  epio_pins_t st_nxt; // its next value
  logic [`EPIO_W-1:0] pa; // pwm owns the pin
  logic [`EPIO_W-1:0] pd; // pwm level per pin
  logic [`EPIO_W-1:0] mo; // selected output level
  logic [`EPIO_W-1:0] me_n; // selected enable, low drives
  logic [`EPIO_W-1:0] mp; // selected pull-up

  //////////////////////////////////////////////////////////////////////
  // per pin selection, pwm over stream over latch
  for (genvar i = 0; i < `EPIO_W; i++) begin : g_pin
    if (i >= PWM_BASE) begin : g_pwm
      assign pa[i] = pwm_act[i-PWM_BASE];
      assign pd[i] = pwm_dat[i-PWM_BASE];
    end else begin : g_nopwm
      assign pa[i] = 1'b0;
      assign pd[i] = 1'b0;
    end
    // RULE10: pwm wins pin
    assign mo[i] = pa[i] ? pd[i] : (strm_act ? strm_dout[i] : latch[i]);
    // RULE2: direction bit drives
    assign me_n[i] = pa[i] ? 1'b0 : (strm_act ? ~strm_drive : dir[i]);
    // RULE5: pull-up only as input
    // RULE12: latch bit gates pull-up
    assign mp[i] = pu_glob & latch[i] & dir[i] & ~strm_act & ~pa[i];
  end

  //////////////////////////////////////////////////////////////////////
  // next pin state
  always_comb begin
    st_nxt = st_r;
    st_nxt.pout = mo;
    st_nxt.oe_n = me_n;
    st_nxt.pu = mp;
    // RULE9: stream input sees pins
    st_nxt.din = pin_in;
    // RULE8: ttl buffers for stream
    st_nxt.ttl = strm_act;
  end

  // state register; reset leaves every pin an input, pulls off
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r.pout <= `EPIO_ZERO_W;
      st_r.oe_n <= `EPIO_ONES_W;
      st_r.pu <= `EPIO_ZERO_W;
      st_r.din <= `EPIO_ZERO_W;
      st_r.ttl <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.pout;
  assign pin_oe_n = st_r.oe_n;
  assign pullup_en = st_r.pu;
  assign strm_din = st_r.din;
  assign ttl_sel = st_r.ttl;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_pull_drive_excl: assert property ( // RULE5
    (pullup_en & ~pin_oe_n) == `EPIO_ZERO_W)
    else $error("pull-up on while pin driven");
  a_top_pwm_prio: assert property ( // RULE10
    pwm_act[2] |=> !pin_oe_n[7] && pin_out[7] == $past(pwm_dat[2]))
    else $error("pwm did not take top pin");
endmodule // epio_pinmux

// ---- verification/epio_board.sv ----
// board side model of the eight port pads
`timescale 1ns/10ps
`include "epio_cfg.svh"
module epio_board (
  input wire logic sys_clk,
  input wire logic [`EPIO_W-1:0] pin_out,
  input wire logic [`EPIO_W-1:0] pin_oe_n,
  input wire logic [`EPIO_W-1:0] pullup_en,
  input wire logic [`EPIO_W-1:0] brd_val,
  input wire logic [`EPIO_W-1:0] brd_en,
  output logic [`EPIO_W-1:0] pin_in
);
  // last pad level, kept so a floating pad never looks stable
  logic [`EPIO_W-1:0] last_r = 8'h00;
  always_comb begin
    for (int i = 0; i < `EPIO_W; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (brd_en[i]) pin_in[i] = brd_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_r[i];
    end
  end
  // undriven pads toggle every cycle
  always_ff @(posedge sys_clk) last_r <= pin_in;
endmodule // epio_board

// ---- verification/tb_top.sv ----
// self-checking bench of the eight pin parallel i/o port
`timescale 1ns/10ps
`include "epio_cfg.svh"
module tb_top;
  logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, ttl_sel;
  logic [31:0] haddr, hwdata, hrdata, t;
  logic [1:0] htrans;
  logic [2:0] hsize, pwm_chan_act, pwm_chan_out;
  logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en, brd_val, brd_en;
  logic [7:0] stream_out_data, stream_in_data;
  logic stream_drive, stream_active, pwm_multi_mode;
  int mismatches = 0;
  int tests_run = 0;
  // one table row: latch, direction, pull enable, board level, board drive
  typedef struct packed {
    logic [7:0] lat, dir;
    logic pu;
    logic [7:0] bv, be;
  } epio_row_t;
  epio_row_t rows [5] = '{
    '{8'hA5, 8'h00, 1'b0, 8'h00, 8'h00},
    '{8'h3C, 8'hFF, 1'b1, 8'h5A, 8'hFF},
    '{8'hF0, 8'h0F, 1'b1, 8'h00, 8'h0F},
    '{8'hFF, 8'hF0, 1'b1, 8'h00, 8'h00},
    '{8'h55, 8'hAA, 1'b0, 8'hFF, 8'hAA}};
  epio_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ttl_sel(ttl_sel),
    .stream_drive(stream_drive), .stream_out_data(stream_out_data),
    .stream_in_data(stream_in_data), .stream_active(stream_active),
    .pwm_multi_mode(pwm_multi_mode), .pwm_chan_act(pwm_chan_act),
    .pwm_chan_out(pwm_chan_out));
  epio_board brd (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .brd_val(brd_val),
    .brd_en(brd_en), .pin_in(pin_in));
  // free running clock, 8 ns
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // wait for hready at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) chk(0, 1, "hready timeout");
  endtask
  // one single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000, "bus response");
  endtask
  // let pins settle then sample off the edge
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
    {hsize, stream_drive, stream_out_data} = {3'b010, 9'h000};
    {pwm_multi_mode, pwm_chan_act, pwm_chan_out} = 7'h00;
    {brd_val, brd_en} = 16'h0000;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(32'(pin_oe_n), 32'h0000_00FF, "oe reset");
    chk(32'(pullup_en), 32'h0000_0000, "pull reset");
    bus(0, `EPIO_OFS_DIR, 0, t);
    chk(t, 32'h0000_00FF, "dir reset");
    bus(0, `EPIO_OFS_NBR, 0, t);
    chk(t, 32'h0000_0000, "pull enable reset");
    bus(0, `EPIO_OFS_STRM, 0, t);
    chk(t, 32'h0000_0000, "stream reset");
    foreach (rows[k]) begin
      brd_val <= rows[k].bv;
      brd_en <= rows[k].be;
      bus(1, `EPIO_OFS_LATCH, 32'(rows[k].lat), t);
      bus(1, `EPIO_OFS_DIR, 32'(rows[k].dir), t);
      bus(1, `EPIO_OFS_NBR, {24'h00_0000, rows[k].pu, 7'h00}, t);
      settle();
      chk(32'(pin_oe_n), 32'(rows[k].dir), "oe row");
      chk(32'(pin_out & ~rows[k].dir),
          32'(rows[k].lat & ~rows[k].dir), "out row");
      chk(32'(pullup_en), rows[k].pu ? 32'(rows[k].lat & rows[k].dir)
          : 32'h0, "pull row");
      bus(0, `EPIO_OFS_PORT, 0, t);
      chk(t, 32'((~rows[k].dir & rows[k].lat) | (rows[k].dir & ~rows[k].be)
          | (rows[k].dir & rows[k].be & rows[k].bv)), "pin read");
      bus(0, `EPIO_OFS_LATCH, 0, t);
      chk(t, 32'(rows[k].lat), "latch read");
    end
    // port data write lands in the latch, read right after
    bus(1, `EPIO_OFS_PORT, 32'h0000_0096, t);
    bus(0, `EPIO_OFS_LATCH, 0, t);
    chk(t, 32'h0000_0096, "port write");
    // unmapped word reads zero and drops writes
    bus(1, 8'h20, 32'h0000_00FF, t);
    bus(0, 8'h20, 0, t);
    chk(t, 32'h0000_0000, "unmapped read");
    bus(0, `EPIO_OFS_LATCH, 0, t);
    chk(t, 32'h0000_0096, "unmapped write dropped");
    bus(1, `EPIO_OFS_LATCH, 32'h0000_00FF, t);
    bus(1, `EPIO_OFS_DIR, 32'h0000_00FF, t);
    bus(1, `EPIO_OFS_NBR, 32'h0000_0080, t);
    @(posedge sys_clk);
    stream_drive <= 1'b1;
    stream_out_data <= 8'hC3;
    bus(1, `EPIO_OFS_STRM, 32'h0000_0001, t);
    settle();
    chk(32'(stream_active), 32'h1, "stream on");
    chk(32'(ttl_sel), 32'h1, "ttl buffers");
    chk(32'(pin_out), 32'h0000_00C3, "stream out");
    chk(32'(pin_oe_n), 32'h0000_0000, "stream drive");
    chk(32'(pullup_en), 32'h0000_0000, "stream pull");
    @(posedge sys_clk);
    stream_drive <= 1'b0;
    brd_val <= 8'h5A;
    brd_en <= 8'hFF;
    settle();
    chk(32'(pin_oe_n), 32'h0000_00FF, "stream float");
    chk(32'(stream_in_data), 32'h0000_005A, "stream in");
    @(posedge sys_clk);
    stream_drive <= 1'b1;
    pwm_chan_act <= 3'b101;
    pwm_chan_out <= 3'b001;
    settle();
    chk(32'(pin_out[7:5]), 32'h3, "pwm over stream");
    @(posedge sys_clk);
    stream_drive <= 1'b0;
    settle();
    chk(32'(pin_oe_n), 32'h0000_005F, "pwm drives");
    @(posedge sys_clk);
    pwm_chan_act <= 3'b000;
    pwm_multi_mode <= 1'b1;
    settle();
    chk(32'(stream_active), 32'h0, "multi off");
    chk(32'(ttl_sel), 32'h0, "multi ttl");
    chk(32'(pullup_en), 32'h0000_00FF, "multi pull");
    // second reset in mid-run
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(32'(pullup_en), 32'h0000_0000, "pull rerun");
    chk(32'(pin_oe_n), 32'h0000_00FF, "oe rerun");
    bus(0, `EPIO_OFS_DIR, 0, t);
    chk(t, 32'h0000_00FF, "dir rerun");
    finish_test();
  end
endmodule // tb_top
